// ===== rtl/pdsr_cfg.svh
// Constants of the divider and input status register slice.
// What this block does
// - Feedback divider bits 15:8 and 7:0 are two RW byte registers feeding the phase detector.
// - After reset the feedback divider low byte reads 0xf9 and the middle byte reads 0x00.
// - Input one divider has 19 bits over three registers, 18:16 in bits 2:0, 7:3 reserved RO.
// - Input dividers take every ratio from 1 to 2 to the 19; software programs only that range.
// - After reset input one divider low byte reads 0x09 and its top field reads zero.
// - Input two has its own 19-bit divider split the same way, top bits in the low three bits.
// - Band codes sit in bits 5:3 for input two and 2:0 for input one; codes 6 and 7 are reserved.
// - Status bit 0 reads 1 only while input one is selected and has no signal loss.
// - Status bit 1 reads 1 only while input two is selected and has no signal loss.
// - The active input status register keeps bits 7:2 reserved and read-only.
// - The live signal loss bit of each input reads 1 while its loss alarm exists.
// - Feedback divider bits 19:16 sit in bits 3:0 of the register just before the middle byte.
`ifndef PDSR_CFG_SVH
`define PDSR_CFG_SVH
`define PDSR_ADDR_FB_TOP 8'h28
`define PDSR_ADDR_FB_MID 8'h29
`define PDSR_ADDR_FB_LOW 8'h2a
`define PDSR_ADDR_IN1_HIGH 8'h2b
`define PDSR_ADDR_IN1_MID 8'h2c
`define PDSR_ADDR_IN1_LOW 8'h2d
`define PDSR_ADDR_IN2_HIGH 8'h2e
`define PDSR_ADDR_IN2_MID 8'h2f
`define PDSR_ADDR_IN2_LOW 8'h30
`define PDSR_ADDR_BAND 8'h37
`define PDSR_ADDR_ACTIVE 8'h80
`define PDSR_ADDR_LOSS 8'h81
`define PDSR_RST_FB 20'h0_00f9
`define PDSR_RST_IN1 19'h0_0009
`define PDSR_RST_IN2 19'h0_0000
`define PDSR_RST_BAND 6'h00
`define PDSR_BAND_MAX 3'h5
`endif

// ===== rtl/pdsr_pkg.sv
// Types of the divider and input status register slice.
package pdsr_pkg;
  typedef struct packed {
    logic [19:0] fb_div;
    logic [18:0] in1_div;
    logic [18:0] in2_div;
    logic [2:0] band1;
    logic [2:0] band2;
    logic [7:0] rdata;
  } pdsr_state_t;
  typedef struct packed {
    logic [19:0] count;
    logic tick;
  } pdsr_div_state_t;
endpackage : pdsr_pkg

// ===== rtl/pdsr_divider.sv
// Programmable divider that divides its input by the code plus one.
`timescale 1ns/1ps
`include "pdsr_cfg.svh"
module pdsr_divider
  import pdsr_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic enable, // Source edge to be counted.
  input wire logic [19:0] code, // Divider code, ratio is code plus one.
  output logic tick // One pulse every code plus one source edges.
);
  pdsr_div_state_t st;
  pdsr_div_state_t next_st;

  // Counts source edges and pulses when the count reaches the code.
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (enable) begin
      if (st.count >= code) begin
        next_st.count = 20'h0_0000;
        next_st.tick = 1'b1;
      end else begin
        next_st.count = st.count + 20'h0_0001;
      end
    end
  end

  // Registers the divider state.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule : pdsr_divider

// ===== rtl/pdsr_loss_status.sv
// Live loss and active input status of the two clock inputs.
`timescale 1ns/1ps
`include "pdsr_cfg.svh"
module pdsr_loss_status
  import pdsr_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic [1:0] signal_loss, // Loss alarm per input, bit 0 is input one.
  input wire logic [1:0] input_select, // Selection per input, bit 0 is input one.
  output logic [1:0] active_flag, // Active reference flag per input.
  output logic [1:0] loss_live // Live loss indication per input.
);
  logic [3:0] st;
  logic [3:0] next_st;

  // Active only when selected and free of signal loss.
  always_comb begin
    next_st[1:0] = input_select & ~signal_loss;
    next_st[3:2] = signal_loss;
  end

  // Registers the flags.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= 4'h0;
    end else begin
      st <= next_st;
    end
  end

  assign active_flag = st[1:0];
  assign loss_live = st[3:2];
endmodule : pdsr_loss_status

// ===== rtl/pdsr_regs.sv
// Register slice holding the feedback and input dividers and input status.
`timescale 1ns/1ps
`include "pdsr_cfg.svh"
module pdsr_regs
  import pdsr_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic reset_n, // Asynchronous reset, active low.
  input wire logic [7:0] reg_addr, // Register address.
  input wire logic reg_write, // Write strobe, one cycle.
  input wire logic [7:0] reg_wdata, // Write data.
  output logic [7:0] reg_rdata, // Read data of the address of the previous cycle.
  input wire logic clock_input_one, // Input one edge enable.
  input wire logic clock_input_two, // Input two edge enable.
  input wire logic feedback_edge, // Feedback source edge enable.
  input wire logic [1:0] input_select, // Selected reference, bit 0 is input one.
  input wire logic [1:0] signal_loss, // Loss alarm, bit 0 is input one.
  output logic input1_tick, // Divided input one to the phase detector.
  output logic input2_tick, // Divided input two to the phase detector.
  output logic feedback_tick, // Divided feedback to the phase detector.
  output logic [2:0] input1_monitor_band, // Offset alarm band of input one.
  output logic [2:0] input2_monitor_band // Offset alarm band of input two.
);
  pdsr_state_t st;
  pdsr_state_t next_st;
  logic [1:0] active_flag;
  logic [1:0] loss_live;

  // Keeps a band field when the written code is reserved, else takes the written code.
  function automatic logic [2:0] band_next(input logic [2:0] cur, input logic [2:0] wr);
    band_next = (wr > `PDSR_BAND_MAX) ? cur : wr;
  endfunction : band_next

  // Register writes and read data.
  always_comb begin
    next_st = st;
    if (reg_write) begin
      unique case (reg_addr)
        `PDSR_ADDR_FB_TOP: next_st.fb_div[19:16] = reg_wdata[3:0];
        `PDSR_ADDR_FB_MID: next_st.fb_div[15:8] = reg_wdata;
        `PDSR_ADDR_FB_LOW: next_st.fb_div[7:0] = reg_wdata;
        `PDSR_ADDR_IN1_HIGH: next_st.in1_div[18:16] = reg_wdata[2:0];
        `PDSR_ADDR_IN1_MID: next_st.in1_div[15:8] = reg_wdata;
        `PDSR_ADDR_IN1_LOW: next_st.in1_div[7:0] = reg_wdata;
        `PDSR_ADDR_IN2_HIGH: next_st.in2_div[18:16] = reg_wdata[2:0];
        `PDSR_ADDR_IN2_MID: next_st.in2_div[15:8] = reg_wdata;
        `PDSR_ADDR_IN2_LOW: next_st.in2_div[7:0] = reg_wdata;
        `PDSR_ADDR_BAND: begin
          next_st.band1 = band_next(st.band1, reg_wdata[2:0]);
          next_st.band2 = band_next(st.band2, reg_wdata[5:3]);
        end
        default: begin
        end
      endcase
    end
    unique case (reg_addr)
      `PDSR_ADDR_FB_TOP: next_st.rdata = {4'h0, st.fb_div[19:16]};
      `PDSR_ADDR_FB_MID: next_st.rdata = st.fb_div[15:8];
      `PDSR_ADDR_FB_LOW: next_st.rdata = st.fb_div[7:0];
      `PDSR_ADDR_IN1_HIGH: next_st.rdata = {5'h00, st.in1_div[18:16]};
      `PDSR_ADDR_IN1_MID: next_st.rdata = st.in1_div[15:8];
      `PDSR_ADDR_IN1_LOW: next_st.rdata = st.in1_div[7:0];
      `PDSR_ADDR_IN2_HIGH: next_st.rdata = {5'h00, st.in2_div[18:16]};
      `PDSR_ADDR_IN2_MID: next_st.rdata = st.in2_div[15:8];
      `PDSR_ADDR_IN2_LOW: next_st.rdata = st.in2_div[7:0];
      `PDSR_ADDR_BAND: next_st.rdata = {2'h0, st.band2, st.band1};
      `PDSR_ADDR_ACTIVE: next_st.rdata = {6'h00, active_flag};
      `PDSR_ADDR_LOSS: next_st.rdata = {5'h00, loss_live, 1'b0};
      default: next_st.rdata = 8'h00;
    endcase
  end

  // Registers the whole state.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st.fb_div <= `PDSR_RST_FB;
      st.in1_div <= `PDSR_RST_IN1;
      st.in2_div <= `PDSR_RST_IN2;
      {st.band2, st.band1} <= `PDSR_RST_BAND;
      st.rdata <= 8'h00;
    end else begin
      st <= next_st;
    end
  end

  // Status of the two inputs.
  pdsr_loss_status u_status (
    .clk(clk),
    .reset_n(reset_n),
    .signal_loss(signal_loss),
    .input_select(input_select),
    .active_flag(active_flag),
    .loss_live(loss_live)
  );

  // Input dividers cover ratios 1 to 2 to the 19.
  pdsr_divider u_in1 (
    .clk(clk),
    .reset_n(reset_n),
    .enable(clock_input_one),
    .code({1'b0, st.in1_div}),
    .tick(input1_tick)
  );
  pdsr_divider u_in2 (
    .clk(clk),
    .reset_n(reset_n),
    .enable(clock_input_two),
    .code({1'b0, st.in2_div}),
    .tick(input2_tick)
  );
  pdsr_divider u_fb (
    .clk(clk),
    .reset_n(reset_n),
    .enable(feedback_edge),
    .code(st.fb_div),
    .tick(feedback_tick)
  );

  assign reg_rdata = st.rdata;
  assign input1_monitor_band = st.band1;
  assign input2_monitor_band = st.band2;
endmodule : pdsr_regs

// ===== verification/pdsr_regs_assertions.sv
// Checker of the divider and input status register slice.
`timescale 1ns/1ps
`include "pdsr_cfg.svh"
module pdsr_regs_chk (
  input logic clk, // Clock.
  input logic reset_n, // Reset.
  input logic [7:0] reg_addr, // Address.
  input logic reg_write, // Write.
  input logic [7:0] reg_wdata, // Data in.
  input logic [7:0] reg_rdata, // Data out.
  input logic [1:0] input_select, // Select.
  input logic [1:0] signal_loss, // Loss.
  input logic [2:0] input1_monitor_band, // Band one.
  input logic [2:0] input2_monitor_band // Band two.
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [3:0] st_q, st_qq;
  logic [7:0] wd_q;
  // Models the two-cycle status read path and keeps the last write data.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= 4'h0;
      st_qq <= 4'h0;
      wd_q <= 8'h00;
    end else begin
      st_q <= {signal_loss, input_select & ~signal_loss};
      st_qq <= st_q;
      wd_q <= reg_wdata;
    end
  end
  sequence s_rd(logic [7:0] a);
    $past(reg_addr) == a;
  endsequence
  sequence s_band_wr;
    reg_write && reg_addr == `PDSR_ADDR_BAND;
  endsequence
  a_in1_rsvd: assert property (s_rd(`PDSR_ADDR_IN1_HIGH) |-> reg_rdata[7:3] == 5'h0)
    else $error("Input one high register reserved bits set.");
  a_in2_rsvd: assert property (s_rd(`PDSR_ADDR_IN2_HIGH) |-> reg_rdata[7:3] == 5'h0)
    else $error("Input two high register reserved bits set.");
  a_act_flags: assert property (s_rd(8'h80) |-> reg_rdata == {6'h00, st_qq[1:0]})
    else $error("Active input flags wrong.");
  a_loss_live: assert property (s_rd(8'h81) |-> reg_rdata == {5'h00, st_qq[3:2], 1'h0})
    else $error("Live signal loss bits wrong.");
  a_band_one_wr: assert property (
    s_band_wr ##0 reg_wdata[2:0] <= 3'h5 |=> input1_monitor_band == wd_q[2:0])
    else $error("Band one not taken.");
  a_band_two_wr: assert property (
    s_band_wr ##0 reg_wdata[5:3] <= 3'h5 |=> input2_monitor_band == wd_q[5:3])
    else $error("Band two not taken.");
  a_band_one_keep: assert property (
    s_band_wr ##0 reg_wdata[2:0] > 3'h5 |=> $stable(input1_monitor_band))
    else $error("Reserved band one code taken.");
  a_band_two_keep: assert property (
    s_band_wr ##0 reg_wdata[5:3] > 3'h5 |=> $stable(input2_monitor_band))
    else $error("Reserved band two code taken.");
  a_band_legal: assert property (input1_monitor_band <= 3'h5 && input2_monitor_band <= 3'h5)
    else $error("Band output holds a reserved code.");
endmodule : pdsr_regs_chk
bind pdsr_regs pdsr_regs_chk chk (.clk, .reset_n, .reg_addr, .reg_write, .reg_wdata, .reg_rdata,
  .input_select, .signal_loss, .input1_monitor_band, .input2_monitor_band);

// ===== verification/pdsr_regs_tb.sv
// Self-checking testbench of the divider and input status register slice.
`timescale 1ns/1ps
module testbench;
  logic clk = 0, reset_n = 0, reg_write = 0, clock_input_one = 0, clock_input_two = 0;
  logic feedback_edge = 0, input1_tick, input2_tick, feedback_tick;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, n1, n2, nf;
  logic [1:0] input_select = 2'h0, signal_loss = 2'h0;
  logic [2:0] input1_monitor_band, input2_monitor_band;
  int error_cnt = 0, comparisons = 0;
  logic [7:0] rst_rows [7][2] = '{'{8'h29, 8'h00}, '{8'h2a, 8'hf9}, '{8'h2b, 8'h00},
    '{8'h2d, 8'h09}, '{8'h2f, 8'h00}, '{8'h37, 8'h00}, '{8'h28, 8'h00}};
  logic [7:0] rows [19][3] = '{'{8'h28, 8'hff, 8'h0f}, '{8'h29, 8'ha5, 8'ha5},
    '{8'h2a, 8'h5a, 8'h5a}, '{8'h2b, 8'hff, 8'h07}, '{8'h2c, 8'h3c, 8'h3c},
    '{8'h2d, 8'hc3, 8'hc3}, '{8'h2e, 8'hff, 8'h07}, '{8'h2f, 8'h12, 8'h12},
    '{8'h30, 8'h34, 8'h34}, '{8'h37, 8'h00, 8'h00}, '{8'h37, 8'h09, 8'h09},
    '{8'h37, 8'h12, 8'h12}, '{8'h37, 8'h1b, 8'h1b}, '{8'h37, 8'h24, 8'h24},
    '{8'h37, 8'hed, 8'h2d}, '{8'h37, 8'h3e, 8'h2d}, '{8'h37, 8'hff, 8'h2d},
    '{8'h80, 8'hff, 8'h00}, '{8'h90, 8'hff, 8'h00}};
  logic [7:0] tick_rows [9][2] = '{'{8'h2b, 8'h00}, '{8'h2c, 8'h00}, '{8'h2d, 8'h02},
    '{8'h2e, 8'h00}, '{8'h2f, 8'h00}, '{8'h30, 8'h04}, '{8'h28, 8'h00}, '{8'h29, 8'h00},
    '{8'h2a, 8'h00}};
  pdsr_regs dut (.clk, .reset_n, .reg_addr, .reg_write, .reg_wdata, .reg_rdata,
    .clock_input_one, .clock_input_two, .feedback_edge, .input_select, .signal_loss,
    .input1_tick, .input2_tick, .feedback_tick, .input1_monitor_band, .input2_monitor_band);
  // Makes the 100 MHz clock.
  initial begin
    forever #5 clk = ~clk;
  end
  // Compares a seen value with its expected value.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Writes one register.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_write = 1;
    @(posedge clk);
    #1 reg_write = 0;
  endtask : wr
  // Reads one register and compares it.
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    #1 reg_addr = a;
    @(posedge clk);
    #1 chk(reg_rdata, e);
  endtask : rc
  // Prints the verdict and ends the run.
  task automatic print_verdict;
    if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  // Cuts a hang short.
  initial begin
    #100000;
    error_cnt++;
    print_verdict;
  end
  // Main sequence.
  initial begin
    repeat (4) @(posedge clk);
    #1 reset_n = 1;
    foreach (rst_rows[i]) rc(rst_rows[i][0], rst_rows[i][1]);
    foreach (rows[i]) begin
      wr(rows[i][0], rows[i][1]);
      rc(rows[i][0], rows[i][2]);
    end
    chk({2'h0, input2_monitor_band, input1_monitor_band}, 8'h2d);
    for (int k = 0; k < 16; k++) begin
      input_select = k[1:0];
      signal_loss = k[3:2];
      rc(8'h80, {6'h00, k[1:0] & ~k[3:2]});
      rc(8'h81, {5'h00, k[3:2], 1'h0});
    end
    foreach (tick_rows[i]) wr(tick_rows[i][0], tick_rows[i][1]);
    clock_input_one = 1;
    clock_input_two = 1;
    feedback_edge = 1;
    repeat (10) @(posedge clk);
    n1 = 8'h00;
    n2 = 8'h00;
    nf = 8'h00;
    repeat (30) begin
      @(posedge clk);
      #1 n1 = n1 + input1_tick;
      n2 = n2 + input2_tick;
      nf = nf + feedback_tick;
    end
    chk(n1, 8'h0a);
    chk(n2, 8'h06);
    chk(nf, 8'h1e);
    reset_n = 0;
    repeat (4) @(posedge clk);
    #1 reset_n = 1;
    foreach (rst_rows[i]) rc(rst_rows[i][0], rst_rows[i][1]);
    print_verdict;
  end
endmodule : testbench
